/* hw/wer_core.sv */
// Wake-up event routing: configuration, route enables, sticky status, outputs
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "wer_params.svh"

module wer_core
   import wer_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic software_event,
   input wire logic consumer_infrared_event,
   input wire logic mouse_event,
   input wire logic keyboard_event,
   input wire logic ring_indicate_two,
   input wire logic ring_indicate_one,
   input wire logic [7:0] gp_event_input,
   input wire logic keyboard_clock_in,
   input wire logic keyboard_data_in,
   input wire logic mouse_clock_in,
   input wire logic mouse_data_in,
   output logic kbc_keyboard_clock,
   output logic kbc_keyboard_data,
   output logic kbc_mouse_clock,
   output logic kbc_mouse_data,
   output logic [1:0] bank_select,
   output logic power_button_pulse_s3_en,
   output logic system_mgmt_interrupt_n,
   output logic wake_controller_irq,
   output logic power_wake_request_n
);

   // Registered state and its next value
   wer_state_t cur;
   wer_state_t nxt;
   wer_bank_t bank;
   logic route_bank;
   logic [4:0] leg_pins;
   logic [3:0] ps2_pins;
   logic [4:0] leg_rise;
   logic [7:0] gp_rise;
   logic [7:0] leg_set;
   logic [7:0] wr_data_leg;
   logic wr_cfg;
   logic wr_wen_leg;
   logic wr_wen_gp;
   logic wr_sts_leg;
   logic wr_sts_gp;
   logic wr_smi_leg;
   logic wr_smi_gp;
   logic wr_irq_leg;
   logic wr_irq_gp;
   logic [7:0] rd_mux;
   logic [7:0] clr_leg;
   logic [7:0] clr_gp;
   logic [7:0] wr_data_cfg;
   logic [7:0] mgmt_hit_leg;
   logic [7:0] mgmt_hit_gp;
   logic [7:0] irq_hit_leg;
   logic [7:0] irq_hit_gp;
   logic [7:0] wake_hit_leg;
   logic [7:0] wake_hit_gp;
   logic mgmt_any;
   logic irq_any;
   logic wake_any;

   // Event pins in legacy status order, keyboard and mouse pins in pair order
   assign leg_pins = {consumer_infrared_event, mouse_event, keyboard_event,
                      ring_indicate_two, ring_indicate_one};
   assign ps2_pins = {mouse_data_in, mouse_clock_in, keyboard_data_in, keyboard_clock_in};

   // Bank decode from the configuration register
   assign bank = wer_bank_t'(cur.cfg[`WER_CFG_BANK_HI:`WER_CFG_BANK_LO]);
   assign route_bank = (bank == WER_BANK_ROUTE);

   // Rising edges of the synchronised event pins
   // A level held high sets its status once; it must fall and rise again
   assign leg_rise = cur.leg_s2 & ~cur.leg_prev;
   assign gp_rise = cur.gp_s2 & ~cur.gp_prev;

   // Place legacy edges into the status layout; software event is same-clock
   always_comb begin
      leg_set = `WER_ZERO_BYTE;
      leg_set[`WER_LEG_SW] = software_event;
      leg_set[`WER_LEG_IR] = leg_rise[4];
      leg_set[`WER_LEG_MOUSE] = leg_rise[3];
      leg_set[`WER_LEG_KBD] = leg_rise[2];
      leg_set[`WER_LEG_RI2] = leg_rise[1];
      leg_set[`WER_LEG_RI1] = leg_rise[0];
   end

   // Reserved bits are dropped on the way in, so they always read back zero
   assign wr_data_leg = reg_wdata & `WER_LEG_MASK;
   assign wr_data_cfg = reg_wdata & `WER_CFG_MASK;

   // Write decode; common registers always visible, routing only in bank 2
   // A routing write outside bank 2 is dropped, not redirected
   assign wr_sts_leg = reg_wr && (reg_addr == `WER_OFF_STS_LEG);
   assign wr_sts_gp = reg_wr && (reg_addr == `WER_OFF_STS_GP);
   assign wr_wen_leg = reg_wr && (reg_addr == `WER_OFF_WEN_LEG);
   assign wr_wen_gp = reg_wr && (reg_addr == `WER_OFF_WEN_GP);
   assign wr_cfg = reg_wr && (reg_addr == `WER_OFF_CFG);
   assign wr_smi_leg = reg_wr && route_bank && (reg_addr == `WER_OFF_SMI_LEG);
   assign wr_smi_gp = reg_wr && route_bank && (reg_addr == `WER_OFF_SMI_GP);
   assign wr_irq_leg = reg_wr && route_bank && (reg_addr == `WER_OFF_IRQ_LEG);
   assign wr_irq_gp = reg_wr && route_bank && (reg_addr == `WER_OFF_IRQ_GP);

   // Write-one-to-clear masks; only a write to a status offset clears anything
   always_comb begin
      clr_leg = `WER_ZERO_BYTE;
      clr_gp = `WER_ZERO_BYTE;
      if (wr_sts_leg) begin
         clr_leg = wr_data_leg;
      end
      if (wr_sts_gp) begin
         clr_gp = reg_wdata;
      end
   end

   // Per-event route hits; the wake enables never gate the interrupt routes
   always_comb begin
      mgmt_hit_leg = cur.sts_leg & cur.smi_leg;
      mgmt_hit_gp = cur.sts_gp & cur.smi_gp;
      irq_hit_leg = cur.sts_leg & cur.irq_leg;
      irq_hit_gp = cur.sts_gp & cur.irq_gp;
      wake_hit_leg = cur.sts_leg & cur.wen_leg;
      wake_hit_gp = cur.sts_gp & cur.wen_gp;
      mgmt_any = |{mgmt_hit_leg, mgmt_hit_gp};
      irq_any = |{irq_hit_leg, irq_hit_gp};
      wake_any = |{wake_hit_leg, wake_hit_gp};
   end

   // Read multiplexer; unmapped or hidden offsets read zero
   always_comb begin
      rd_mux = `WER_ZERO_BYTE;
      case (reg_addr)
         // Status, wake enables and configuration answer in every bank
         `WER_OFF_STS_LEG: begin
            rd_mux = cur.sts_leg;
         end
         `WER_OFF_STS_GP: begin
            rd_mux = cur.sts_gp;
         end
         `WER_OFF_WEN_LEG: begin
            rd_mux = cur.wen_leg;
         end
         `WER_OFF_WEN_GP: begin
            rd_mux = cur.wen_gp;
         end
         `WER_OFF_CFG: begin
            rd_mux = cur.cfg;
         end
         `WER_OFF_SMI_LEG: begin
            if (route_bank) begin
               rd_mux = cur.smi_leg;
            end
         end
         `WER_OFF_SMI_GP: begin
            if (route_bank) begin
               rd_mux = cur.smi_gp;
            end
         end
         `WER_OFF_IRQ_LEG: begin
            if (route_bank) begin
               rd_mux = cur.irq_leg;
            end
         end
         `WER_OFF_IRQ_GP: begin
            if (route_bank) begin
               rd_mux = cur.irq_gp;
            end
         end
         default: begin
            rd_mux = `WER_ZERO_BYTE;
         end
      endcase
   end

   always_comb begin
      nxt = cur;

      // Two-stage synchronisers; only the second stage feeds logic
      nxt.leg_s1 = leg_pins;
      nxt.leg_s2 = cur.leg_s1;
      nxt.leg_prev = cur.leg_s2;
      nxt.gp_s1 = gp_event_input;
      nxt.gp_s2 = cur.gp_s1;
      nxt.gp_prev = cur.gp_s2;
      nxt.ps2_s1 = ps2_pins;
      nxt.ps2_s2 = cur.ps2_s1;

      // Keyboard and mouse pair exchange
      // Swap acts on synchronised bits, so the outputs see no pin metastability
      if (cur.cfg[`WER_CFG_SWAP]) begin
         nxt.ps2_out[`WER_PS2_KCLK] = cur.ps2_s2[`WER_PS2_MCLK];
         nxt.ps2_out[`WER_PS2_KDAT] = cur.ps2_s2[`WER_PS2_MOUSE_DATA_IN];
         nxt.ps2_out[`WER_PS2_MCLK] = cur.ps2_s2[`WER_PS2_KCLK];
         nxt.ps2_out[`WER_PS2_MOUSE_DATA_IN] = cur.ps2_s2[`WER_PS2_KDAT];
      end else begin
         nxt.ps2_out = cur.ps2_s2;
      end

      // Register writes; reserved bits held at zero
      if (wr_cfg) begin
         nxt.cfg = wr_data_cfg;
      end
      if (wr_wen_leg) begin
         nxt.wen_leg = wr_data_leg;
      end
      if (wr_wen_gp) begin
         nxt.wen_gp = reg_wdata;
      end
      if (wr_smi_leg) begin
         nxt.smi_leg = wr_data_leg;
      end
      if (wr_smi_gp) begin
         nxt.smi_gp = reg_wdata;
      end
      if (wr_irq_leg) begin
         nxt.irq_leg = wr_data_leg;
      end
      if (wr_irq_gp) begin
         nxt.irq_gp = reg_wdata;
      end

      // Sticky status: write one clears, a new event in the same cycle wins
      nxt.sts_leg = (cur.sts_leg & ~clr_leg) | leg_set;
      nxt.sts_gp = (cur.sts_gp & ~clr_gp) | gp_rise;

      // Routed outputs; only the wake request is gated by the wake enables
      // They lag the status by one clock and release one clock after a clear
      nxt.mgmt_n = ~mgmt_any;
      nxt.irq = irq_any;
      nxt.pwu_n = ~wake_any;

      // Read data stands for exactly the cycle after the strobe
      nxt.rdata = reg_rd ? rd_mux : `WER_ZERO_BYTE;
   end

   // Reset leaves every route disabled and every output inactive
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur.leg_s1 <= '0;
         cur.leg_s2 <= '0;
         cur.leg_prev <= '0;
         cur.gp_s1 <= '0;
         cur.gp_s2 <= '0;
         cur.gp_prev <= '0;
         cur.ps2_s1 <= '0;
         cur.ps2_s2 <= '0;
         cur.ps2_out <= '0;
         cur.cfg <= `WER_RST_BYTE;
         cur.wen_leg <= `WER_RST_BYTE;
         cur.wen_gp <= `WER_RST_BYTE;
         cur.smi_leg <= `WER_RST_BYTE;
         cur.smi_gp <= `WER_RST_BYTE;
         cur.irq_leg <= `WER_RST_BYTE;
         cur.irq_gp <= `WER_RST_BYTE;
         cur.sts_leg <= `WER_RST_BYTE;
         cur.sts_gp <= `WER_RST_BYTE;
         cur.rdata <= `WER_RST_BYTE;
         cur.mgmt_n <= 1'b1;
         cur.irq <= 1'b0;
         cur.pwu_n <= 1'b1;
      end else begin
         cur <= nxt;
      end
   end

   // Every pin-level output comes straight from a flip-flop
   assign reg_rdata = cur.rdata;
   assign kbc_keyboard_clock = cur.ps2_out[`WER_PS2_KCLK];
   assign kbc_keyboard_data = cur.ps2_out[`WER_PS2_KDAT];
   assign kbc_mouse_clock = cur.ps2_out[`WER_PS2_MCLK];
   assign kbc_mouse_data = cur.ps2_out[`WER_PS2_MOUSE_DATA_IN];
   assign bank_select = cur.cfg[`WER_CFG_BANK_HI:`WER_CFG_BANK_LO];
   assign power_button_pulse_s3_en = cur.cfg[`WER_CFG_PB_S3];
   assign system_mgmt_interrupt_n = cur.mgmt_n;
   assign wake_controller_irq = cur.irq;
   assign power_wake_request_n = cur.pwu_n;

endmodule : wer_core

/* pkg/wer_params.svh */
// Offsets, reset values, field positions and masks of the wake routing block
`ifndef WER_PARAMS_SVH
`define WER_PARAMS_SVH

`define WER_OFF_STS_LEG 8'h00
`define WER_OFF_STS_GP 8'h01
`define WER_OFF_WEN_LEG 8'h02
`define WER_OFF_WEN_GP 8'h03
`define WER_OFF_CFG 8'h04
`define WER_OFF_SMI_LEG 8'h13
`define WER_OFF_SMI_GP 8'h14
`define WER_OFF_IRQ_LEG 8'h15
`define WER_OFF_IRQ_GP 8'h16

`define WER_RST_BYTE 8'h00
`define WER_ZERO_BYTE 8'h00
`define WER_LEG_MASK 8'h5F
`define WER_CFG_MASK 8'h0F

`define WER_CFG_BANK_HI 1
`define WER_CFG_BANK_LO 0
`define WER_CFG_SWAP 2
`define WER_CFG_PB_S3 3

`define WER_LEG_SW 6
`define WER_LEG_IR 4
`define WER_LEG_MOUSE 3
`define WER_LEG_KBD 2
`define WER_LEG_RI2 1
`define WER_LEG_RI1 0
`define WER_LEG_PIN_W 5
`define WER_PS2_W 4
`define WER_PS2_KCLK 0
`define WER_PS2_KDAT 1
`define WER_PS2_MCLK 2
`define WER_PS2_MOUSE_DATA_IN 3

`endif

/* pkg/wer_pkg.sv */
// Types shared by the wake routing block
package wer_pkg;

   typedef enum logic [1:0] {
      WER_BANK_KBM,
      WER_BANK_IR,
      WER_BANK_ROUTE,
      WER_BANK_GPIO
   } wer_bank_t;

   typedef struct packed {
      logic [4:0] leg_s1;
      logic [4:0] leg_s2;
      logic [4:0] leg_prev;
      logic [7:0] gp_s1;
      logic [7:0] gp_s2;
      logic [7:0] gp_prev;
      logic [3:0] ps2_s1;
      logic [3:0] ps2_s2;
      logic [3:0] ps2_out;
      logic [7:0] cfg;
      logic [7:0] wen_leg;
      logic [7:0] wen_gp;
      logic [7:0] smi_leg;
      logic [7:0] smi_gp;
      logic [7:0] irq_leg;
      logic [7:0] irq_gp;
      logic [7:0] sts_leg;
      logic [7:0] sts_gp;
      logic [7:0] rdata;
      logic mgmt_n;
      logic irq;
      logic pwu_n;
   } wer_state_t;

endpackage : wer_pkg

/* verification/wer_core_sva.sv */
// Port-level assertions for the wake routing block
`timescale 1ns/10ps
module wer_core_sva (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic software_event,
   input wire logic keyboard_clock_in,
   input wire logic mouse_clock_in,
   input wire logic kbc_keyboard_clock,
   input wire logic [1:0] bank_select,
   input wire logic system_mgmt_interrupt_n,
   input wire logic wake_controller_irq,
   input wire logic power_wake_request_n
);
   logic [7:0] cfg_q, smi_q, smigp_q, irq_q, wen_q;
   // Mirror of software writes, routing ones only while bank 2 is selected
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {cfg_q, smi_q, smigp_q, irq_q, wen_q} <= '0;
      end else if (reg_wr) begin
         if (reg_addr == 8'h04) cfg_q <= reg_wdata;
         if (reg_addr == 8'h02) wen_q <= reg_wdata;
         if (reg_addr == 8'h13 && cfg_q[1:0] == 2'h2) smi_q <= reg_wdata;
         if (reg_addr == 8'h14 && cfg_q[1:0] == 2'h2) smigp_q <= reg_wdata;
         if (reg_addr == 8'h15 && cfg_q[1:0] == 2'h2) irq_q <= reg_wdata;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence cfg_write;
      reg_wr && reg_addr == 8'h04;
   endsequence
   sequence cfg_readback;
      cfg_write ##2 reg_rd && reg_addr == 8'h04;
   endsequence
   sequence route_hit(en);
      software_event && en;
   endsequence
   chk_bank_follow: assert property (
      cfg_write |=> bank_select == $past(reg_wdata[1:0])) else $error("bank select stale");
   chk_cfg_readback: assert property (
      cfg_readback |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 3)}) else $error("config readback");
   chk_bank_gate: assert property (
      reg_rd && reg_addr inside {8'h13, 8'h14, 8'h15} && bank_select != 2'h2
      |=> reg_rdata == 8'h00) else $error("routing visible outside bank 2");
   chk_swap_path: assert property (
      $stable(cfg_q[2])[*3] |-> kbc_keyboard_clock == (cfg_q[2] ? $past(mouse_clock_in, 3)
      : $past(keyboard_clock_in, 3))) else $error("keyboard clock path wrong");
   chk_sw_mgmt: assert property (
      route_hit(smi_q[6]) |-> ##2 !system_mgmt_interrupt_n) else $error("mgmt not raised");
   chk_sw_irq: assert property (
      route_hit(irq_q[6]) |-> ##2 wake_controller_irq) else $error("irq not raised");
   chk_sw_wake: assert property (
      route_hit(wen_q[6]) |-> ##2 !power_wake_request_n) else $error("wake not raised");
   chk_mgmt_quiet: assert property (
      $past(smi_q == 8'h00 && smigp_q == 8'h00) |-> system_mgmt_interrupt_n)
      else $error("mgmt with no route");
   chk_mgmt_sticky: assert property (
      !system_mgmt_interrupt_n && !reg_wr && !$past(reg_wr) |=> !system_mgmt_interrupt_n)
      else $error("mgmt dropped");
endmodule : wer_core_sva

bind wer_core wer_core_sva wer_core_sva_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .software_event, .keyboard_clock_in, .mouse_clock_in, .kbc_keyboard_clock,
   .bank_select, .system_mgmt_interrupt_n, .wake_controller_irq, .power_wake_request_n);

/* verification/wer_core_tb.sv */
// Self-checking bench for the wake routing block
`timescale 1ns/10ps
module wer_core_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, gp = 8'h00, m, reg_rdata, smi_count;
   logic reg_wr = 1'b0, reg_rd = 1'b0, sw = 1'b0, lg, mgmt_n, irq, pwu_n, pb;
   logic [4:0] leg = 5'h00;
   logic [3:0] kbm = 4'h0, kbo;
   logic [1:0] bank;
   int errors = 0;
   int check_count = 0;
   always #12.5 clk = ~clk;
   wer_core wer_core_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .software_event(sw), .consumer_infrared_event(leg[4]), .mouse_event(leg[3]),
      .keyboard_event(leg[2]), .ring_indicate_two(leg[1]), .ring_indicate_one(leg[0]),
      .gp_event_input(gp), .keyboard_clock_in(kbm[0]), .keyboard_data_in(kbm[1]),
      .mouse_clock_in(kbm[2]), .mouse_data_in(kbm[3]), .kbc_keyboard_clock(kbo[0]),
      .kbc_keyboard_data(kbo[1]), .kbc_mouse_clock(kbo[2]), .kbc_mouse_data(kbo[3]),
      .bank_select(bank), .power_button_pulse_s3_en(pb), .system_mgmt_interrupt_n(mgmt_n),
      .wake_controller_irq(irq), .power_wake_request_n(pwu_n));
   wer_host_model wer_host_model_i (.clk(clk), .sys_rst(sys_rst),
      .system_mgmt_interrupt_n(mgmt_n), .smi_count(smi_count));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk("rdata", reg_rdata, exp);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : tick
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      #100us;
      errors++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h04, 8'h00);
      rd(8'h13, 8'h00);
      for (int b = 0; b < 4; b++) begin
         wr(8'h04, 8'(b));
         tick(1);
         chk("bank", 8'(bank), 8'(b));
      end
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'h0F);
      chk("pb", 8'(pb), 8'h01);
      wr(8'h04, 8'h02);
      rd(8'h14, 8'h00);
      wr(8'h13, 8'hFF);
      rd(8'h13, 8'h5F);
      wr(8'h14, 8'hFF);
      rd(8'h14, 8'hFF);
      wr(8'h15, 8'hFF);
      rd(8'h15, 8'h5F);
      wr(8'h04, 8'h00);
      wr(8'h13, 8'h00);
      wr(8'h04, 8'h02);
      rd(8'h13, 8'h5F);
      wr(8'h13, 8'h40);
      wr(8'h15, 8'h40);
      wr(8'h02, 8'h40);
      @(posedge clk) sw <= 1'b1;
      @(posedge clk) sw <= 1'b0;
      tick(3);
      chk("wake", 8'(pwu_n), 8'h00);
      tick(5);
      chk("mgmt", 8'(mgmt_n), 8'h00);
      rd(8'h00, 8'h40);
      wr(8'h00, 8'h40);
      tick(2);
      chk("mgmt", 8'(mgmt_n), 8'h01);
      for (int j = 0; j < 13; j++) begin
         lg = j < 5;
         m = lg ? 8'h01 << j : 8'h01 << (j - 5);
         wr(lg ? 8'h13 : 8'h14, m);
         wr(lg ? 8'h15 : 8'h16, m);
         wr(lg ? 8'h02 : 8'h03, j[0] ? m : 8'h00);
         if (lg) leg[j] <= 1'b1;
         else gp[j - 5] <= 1'b1;
         tick(6);
         chk("mgmt", 8'(mgmt_n), 8'h00);
         chk("irq", 8'(irq), 8'h01);
         chk("wake", 8'(pwu_n), 8'(!j[0]));
         rd(lg ? 8'h00 : 8'h01, m);
         @(posedge clk);
         leg <= 5'h00;
         gp <= 8'h00;
         wr(lg ? 8'h00 : 8'h01, m);
         tick(2);
         chk("mgmt", 8'(mgmt_n), 8'h01);
         chk("irq", 8'(irq), 8'h00);
         chk("wake", 8'(pwu_n), 8'h01);
      end
      chk("smi count", smi_count, 8'h0E);
      @(posedge clk);
      kbm <= 4'h3;
      tick(4);
      chk("kbc", 8'(kbo), 8'h03);
      wr(8'h04, 8'h06);
      tick(4);
      chk("kbc", 8'(kbo), 8'h0C);
      @(posedge clk);
      kbm <= 4'h0;
      rd(8'h30, 8'h00);
      tick(4);
      @(posedge clk);
      sys_rst <= 1'b1;
      tick(2);
      @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h04, 8'h00);
      wr(8'h04, 8'h02);
      rd(8'h15, 8'h00);
      close_out();
   end
endmodule : wer_core_tb

/* verification/wer_host_model.sv */
// Host side model that counts management interrupt assertions
`timescale 1ns/10ps
module wer_host_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic system_mgmt_interrupt_n,
   output logic [7:0] smi_count
);
   logic last_n;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_n <= 1'b1;
         smi_count <= 8'h00;
      end else begin
         last_n <= system_mgmt_interrupt_n;
         if (last_n && !system_mgmt_interrupt_n) smi_count <= smi_count + 8'h01;
      end
   end
endmodule : wer_host_model
